// ### core/rps_pkg.sv
// package of constants and types for the reset pin sequencer
package rps_pkg;

	// ---------------------------------------------------------------
	// register offsets (byte addresses on the apb bus)
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00; // control bits
	localparam logic [7:0] OFF_STATUS = 8'h04; // sticky reset source flags
	localparam logic [7:0] OFF_MASK   = 8'h08; // interrupt mask
	localparam logic [7:0] OFF_CFG    = 8'h0C; // latched start-up config
	localparam logic [7:0] OFF_STATE  = 8'h10; // sequencer state

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int CTRL_BIDIR_BIT = 0; // bidir_reset_enable
	localparam int CTRL_PWDCF_BIT = 1; // powerdown_config_select
	localparam int FLG_SW         = 0; // software reset
	localparam int FLG_WDT        = 1; // watchdog reset
	localparam int FLG_SHORT      = 2; // synchronous short hardware
	localparam int FLG_LONG       = 3; // synchronous long hardware
	localparam int FLG_ASYNC      = 4; // asynchronous hardware
	localparam int FLG_POR        = 5; // asynchronous power-on
	localparam int NFLG           = 6; // number of source flags

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [1:0]      CTRL_RST = 2'h0;
	localparam logic [NFLG-1:0] FLG_RST  = 6'h00;
	localparam logic [NFLG-1:0] MASK_RST = 6'h00;
	localparam logic [15:0]     CFG_RST  = 16'hFFFF;

	// ---------------------------------------------------------------
	// port 0 sample masks per reset kind
	// ---------------------------------------------------------------
	localparam logic [15:0] P0_MSK_SWWD  = 16'h1F00; // bits 12..8
	localparam logic [15:0] P0_SET_SWWD  = 16'h00FC; // bits 7..2 forced to 1
	localparam logic [15:0] P0_MSK_SHORT = 16'h1FFF; // all but top three
	localparam logic [15:0] P0_MSK_ALL   = 16'hFFFF; // all sixteen

	// ---------------------------------------------------------------
	// timing, in clock_phase_unit ticks
	// ---------------------------------------------------------------
	localparam int TCL_PER_CLK  = 1;    // CLK cycles per clock phase unit
	localparam int SEQ_TCL      = 1024; // internal reset sequence length
	localparam int SAMPLE_TCL   = 8;    // filtered input sample point
	localparam int FILTER_TCL   = 4;    // least low time of a hw reset
	localparam int CNT_W        = 11;   // sequence counter width

	// ---------------------------------------------------------------
	// sequencer states, one-hot
	// ---------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_ASYNC = 5'b00001, // held in async reset while input low
		ST_SEQ   = 5'b00010, // internal reset sequence running
		ST_POST  = 5'b00100, // waiting to sample filtered input
		ST_INIT  = 5'b01000, // initialization until end of init
		ST_RUN   = 5'b10000  // normal operation
	} rps_state_t;

endpackage : rps_pkg

// ### core/rps_tick.sv
// clock phase unit enable divider
`timescale 1ns/1ps
`default_nettype none
module rps_tick #(
	parameter int DIV = 1 // CLK cycles per enable pulse
) (
	input  wire logic CLK,  // system clock
	input  wire logic SRST, // synchronous reset, active high
	output logic      TICK  // one-cycle enable pulse
);
	// ---------------------------------------------------------------
	// divider
	// ---------------------------------------------------------------
	logic [15:0] cnt_ff; // cycles since last pulse

	// count up, pulse at wrap; DIV of one gives a pulse every cycle
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cnt_ff <= 16'h0000;
			TICK   <= 1'b0;
		end else if (cnt_ff == 16'(DIV - 1)) begin
			cnt_ff <= 16'h0000;
			TICK   <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
			TICK   <= 1'b0;
		end
	end
endmodule : rps_tick
`default_nettype wire

// ### core/rps_seq.sv
// reset pin sequencer with apb register file and interrupt
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rps_seq
	import rps_pkg::*;
#(
	parameter int SEQ_LEN = SEQ_TCL // sequence length in phase units
) (
	input  wire logic        CLK,        // system clock
	input  wire logic        SRST,       // synchronous reset, active high
	input  wire logic        PSEL,       // apb select
	input  wire logic        PENABLE,    // apb enable
	input  wire logic        PWRITE,     // apb direction
	input  wire logic [7:0]  PADDR,      // apb byte address
	input  wire logic [31:0] PWDATA,     // apb write data
	output logic             PREADY,     // apb ready
	output logic [31:0]      PRDATA,     // apb read data
	output logic             PSLVERR,    // apb error
	input  wire logic        RESET_INPUT_PIN_I,    // reset_input_pin level, low active
	output logic             RESET_INPUT_PIN_O,    // reset_input_pin drive value
	output logic             RESET_INPUT_PIN_OE,   // reset_input_pin pull-down on
	output logic             RESET_OUTPUT_PIN_N,   // reset_output_pin, low active
	input  wire logic        RPD_I,      // reset_powerdown_cap_pin level
	output logic             RPD_PD,     // cap pin pull-down on
	output logic             RPD_PU,     // cap pin pull-up on
	input  wire logic [15:0] P0_I,       // port 0 configuration pins
	output logic [15:0]      P0_CFG,     // latched configuration
	input  wire logic        SW_RST,     // software reset request pulse
	input  wire logic        WDT_RST,    // watchdog reset request pulse
	input  wire logic        END_OF_INITIALIZATION_INSTRUCTION,      // end of init executed, pulse
	output logic             CORE_RST,   // internal reset state
	output logic             IRQ         // reset source interrupt
);
	// ---------------------------------------------------------------
	// state and storage
	// ---------------------------------------------------------------
	rps_state_t            state_ff;   // sequencer state
	logic [CNT_W-1:0]      cnt_ff;     // phase unit counter
	logic [2:0]            low_ff;     // input low filter counter
	logic [NFLG-1:0]       kind_ff;    // kind of running reset, one-hot
	logic                  bidir_ff;   // pull-down armed for this sequence
	logic [1:0]            ctrl_ff;    // control register
	logic [NFLG-1:0]       flg_ff;     // sticky source flags
	logic [NFLG-1:0]       mask_ff;    // interrupt mask
	logic                  rpd_s1_ff;  // cap pin synchroniser, stage one
	logic                  rpd_ff;     // cap pin synchronised level
	logic                  clock_phase_unit;        // phase unit enable
	logic                  wr_en;      // apb write takes effect
	logic [NFLG-1:0]       set_flg;    // flags set this cycle
	logic                  hw_req;     // hardware reset start request
	logic                  hw_async;   // started request is asynchronous
	logic                  seq_end;    // sequence completes this cycle
	logic                  post_end;   // sample point reached

	rps_tick #(.DIV(TCL_PER_CLK)) u_tick (
		.CLK  (CLK),
		.SRST (SRST),
		.TICK (clock_phase_unit)
	);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// port 0 latch value for a reset kind, old value for unsampled bits except bits 7..2 forced to 1 on sw/wdt
	function automatic logic [15:0] p0_latch(input logic [NFLG-1:0] k,
			input logic [15:0] pins, input logic [15:0] old);
		logic [15:0] m;
		m = P0_MSK_ALL;
		if (k[FLG_SW] || k[FLG_WDT]) begin
			m = P0_MSK_SWWD;
		end else if (k[FLG_SHORT]) begin
			m = P0_MSK_SHORT;
		end
		p0_latch = (pins & m) | (old & ~m);
		if (k[FLG_SW] || k[FLG_WDT]) begin
			p0_latch = p0_latch | P0_SET_SWWD;
		end
	endfunction : p0_latch

	// one-hot flag vector for a position
	function automatic logic [NFLG-1:0] onehot(input int pos);
		onehot = NFLG'(1) << pos;
	endfunction : onehot

	// ---------------------------------------------------------------
	// cap pin synchroniser
	// ---------------------------------------------------------------
	// two stages; only the second stage is looked at by the logic
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rpd_s1_ff <= 1'b0;
			rpd_ff    <= 1'b0;
		end else begin
			rpd_s1_ff <= RPD_I;
			rpd_ff    <= rpd_s1_ff;
		end
	end

	// ---------------------------------------------------------------
	// hardware reset detection
	// ---------------------------------------------------------------
	// filter: a low must last FILTER_TCL units to count as a reset;
	// a low cap pin skips the filter and goes asynchronous at once
	always_comb begin
		hw_async = ~RESET_INPUT_PIN_I & ~rpd_ff;
		hw_req   = hw_async | (low_ff == 3'(FILTER_TCL));
	end

	// low time counter, counts only in init/run; a low seen while a
	// sequence runs is marked used up, so one long press cannot start
	// a second short sequence once init begins with the pin still low
	always_ff @(posedge CLK) begin
		if (SRST || RESET_INPUT_PIN_I) begin
			low_ff <= 3'h0;
		end else if (state_ff != ST_INIT && state_ff != ST_RUN) begin
			low_ff <= 3'(FILTER_TCL + 1);
		end else if (clock_phase_unit && low_ff < 3'(FILTER_TCL)) begin
			low_ff <= low_ff + 3'h1;
		end
	end

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	assign seq_end  = state_ff == ST_SEQ && clock_phase_unit
		&& cnt_ff == CNT_W'(SEQ_LEN - 1);
	assign post_end = state_ff == ST_POST && clock_phase_unit
		&& cnt_ff == CNT_W'(SAMPLE_TCL - 1);

	// state, counter, reset kind and pull-down arming
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_ff <= ST_SEQ;
			cnt_ff   <= '0;
			kind_ff  <= onehot(FLG_POR);
			bidir_ff <= 1'b0;
		end else begin
			unique case (state_ff)
			ST_ASYNC: begin
				// held until the input is released
				cnt_ff <= '0;
				if (RESET_INPUT_PIN_I) begin
					state_ff <= ST_SEQ;
				end
			end
			ST_SEQ: begin
				if (clock_phase_unit) begin
					cnt_ff <= cnt_ff + CNT_W'(1);
				end
				// cap falls under a low input: switch to async
				if (!bidir_ff && !RESET_INPUT_PIN_I && !rpd_ff
						&& !kind_ff[FLG_POR]) begin
					state_ff <= ST_ASYNC;
					kind_ff  <= onehot(FLG_ASYNC);
				end else if (seq_end) begin
					state_ff <= ST_POST;
					cnt_ff   <= '0;
				end
			end
			ST_POST: begin
				if (clock_phase_unit) begin
					cnt_ff <= cnt_ff + CNT_W'(1);
				end
				if (post_end) begin
					cnt_ff   <= '0;
					bidir_ff <= 1'b0;
					if (!RESET_INPUT_PIN_I && kind_ff[FLG_SHORT]) begin
						kind_ff  <= onehot(FLG_LONG);
						state_ff <= ST_INIT;
					end else if (!RESET_INPUT_PIN_I && bidir_ff) begin
						// bidir sw/wdt degenerates to hardware
						kind_ff  <= onehot(FLG_SHORT);
						state_ff <= ST_SEQ;
					end else begin
						state_ff <= ST_INIT;
					end
				end
			end
			ST_INIT, ST_RUN: begin
				cnt_ff <= '0;
				if (hw_req) begin
					state_ff <= hw_async ? ST_ASYNC : ST_SEQ;
					kind_ff  <= hw_async ? onehot(FLG_ASYNC)
						: onehot(FLG_SHORT);
					bidir_ff <= ctrl_ff[CTRL_BIDIR_BIT] & ~hw_async;
				end else if (SW_RST || WDT_RST) begin
					state_ff <= ST_SEQ;
					kind_ff  <= SW_RST ? onehot(FLG_SW) : onehot(FLG_WDT);
					bidir_ff <= ctrl_ff[CTRL_BIDIR_BIT];
				end else if (END_OF_INITIALIZATION_INSTRUCTION && state_ff == ST_INIT) begin
					state_ff <= ST_RUN;
				end
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// pin drivers
	// ---------------------------------------------------------------
	// open-drain reset pin: drive value is always low, enable pulls;
	// released at once when the cap pin reads low
	always_ff @(posedge CLK) begin
		if (SRST) begin
			RESET_INPUT_PIN_O  <= 1'b0;
			RESET_INPUT_PIN_OE <= 1'b0;
		end else begin
			RESET_INPUT_PIN_O  <= 1'b0;
			RESET_INPUT_PIN_OE <= state_ff == ST_SEQ && bidir_ff && rpd_ff
				&& !seq_end;
		end
	end

	// reset output low from any sequence start until end of init
	always_ff @(posedge CLK) begin
		if (SRST) begin
			RESET_OUTPUT_PIN_N <= 1'b0;
			CORE_RST <= 1'b1;
		end else begin
			RESET_OUTPUT_PIN_N <= state_ff == ST_RUN
				|| (state_ff == ST_INIT && END_OF_INITIALIZATION_INSTRUCTION && !hw_req
				&& !SW_RST && !WDT_RST);
			CORE_RST <= state_ff == ST_ASYNC || state_ff == ST_SEQ
				|| state_ff == ST_POST;
		end
	end

	// cap pin pull-down follows a low input, pull-up only after the
	// sequence so that it cannot fight the discharge
	always_ff @(posedge CLK) begin
		if (SRST) begin
			RPD_PD <= 1'b0;
			RPD_PU <= 1'b0;
		end else begin
			RPD_PD <= ~RESET_INPUT_PIN_I;
			RPD_PU <= ctrl_ff[CTRL_PWDCF_BIT]
				&& (state_ff == ST_INIT || state_ff == ST_RUN);
		end
	end

	// port 0 configuration, latched at sequence completion
	always_ff @(posedge CLK) begin
		if (SRST) begin
			P0_CFG <= CFG_RST;
		end else if (seq_end) begin
			P0_CFG <= p0_latch(kind_ff, P0_I, P0_CFG);
		end else if (post_end && !RESET_INPUT_PIN_I && kind_ff[FLG_SHORT]) begin
			P0_CFG <= P0_I;
		end
	end

	// ---------------------------------------------------------------
	// apb slave
	// ---------------------------------------------------------------
	assign wr_en = PSEL && PENABLE && PREADY && PWRITE;

	// zero wait states: ready and data prepared at the setup edge
	always_ff @(posedge CLK) begin
		if (SRST) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= PSEL && !PENABLE;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			if (PSEL && !PENABLE) begin
				unique case (PADDR)
				OFF_CTRL:   PRDATA <= {30'h0, ctrl_ff};
				OFF_STATUS: PRDATA <= {26'h0, flg_ff};
				OFF_MASK:   PRDATA <= {26'h0, mask_ff};
				OFF_CFG:    PRDATA <= {16'h0, P0_CFG};
				OFF_STATE:  PRDATA <= {27'h0, state_ff};
				default:    PSLVERR <= 1'b1; // unmapped
				endcase
			end
		end
	end

	// control: bidir enable writable only during init, every sequence
	// clears it; the powerdown select keeps its value
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ctrl_ff <= CTRL_RST;
		end else if (state_ff != ST_INIT && state_ff != ST_RUN) begin
			ctrl_ff[CTRL_BIDIR_BIT] <= 1'b0;
		end else if (wr_en && PADDR == OFF_CTRL) begin
			ctrl_ff[CTRL_PWDCF_BIT] <= PWDATA[CTRL_PWDCF_BIT];
			if (state_ff == ST_INIT) begin
				ctrl_ff[CTRL_BIDIR_BIT] <= PWDATA[CTRL_BIDIR_BIT];
			end
		end
	end

	// ---------------------------------------------------------------
	// source flags and interrupt
	// ---------------------------------------------------------------
	// the final kind is flagged when init begins, so a degenerated
	// software or watchdog reset never shows its original source
	assign set_flg = (post_end && state_ff == ST_POST
		&& !(!RESET_INPUT_PIN_I && bidir_ff && !kind_ff[FLG_SHORT]))
		? ((!RESET_INPUT_PIN_I && kind_ff[FLG_SHORT]) ? onehot(FLG_LONG)
		: kind_ff) : '0;

	// write one to clear; a set in the same cycle wins
	always_ff @(posedge CLK) begin
		if (SRST) begin
			flg_ff <= FLG_RST;
		end else begin
			flg_ff <= (flg_ff & ~((wr_en && PADDR == OFF_STATUS)
				? PWDATA[NFLG-1:0] : '0)) | set_flg;
		end
	end

	// mask register and level interrupt
	always_ff @(posedge CLK) begin
		if (SRST) begin
			mask_ff <= MASK_RST;
			IRQ     <= 1'b0;
		end else begin
			if (wr_en && PADDR == OFF_MASK) begin
				mask_ff <= PWDATA[NFLG-1:0];
			end
			IRQ <= |(flg_ff & mask_ff);
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	AST_PD_ONLY_SEQ: assert property (@(posedge CLK) disable iff (SRST)
		RESET_INPUT_PIN_OE |-> $past(state_ff) == ST_SEQ && $past(bidir_ff))
		else $error("reset pin pulled outside a bidir sequence");
	AST_RESET_OUTPUT_PIN_INIT: assert property (@(posedge CLK) disable iff (SRST)
		$rose(RESET_OUTPUT_PIN_N) |-> $past(state_ff == ST_INIT && END_OF_INITIALIZATION_INSTRUCTION))
		else $error("reset output released without end of init");
	AST_PU_AFTER_SEQ: assert property (@(posedge CLK) disable iff (SRST)
		RPD_PU |-> $past(ctrl_ff[CTRL_PWDCF_BIT])
		&& $past(state_ff) != ST_SEQ)
		else $error("cap pull-up on during sequence or unselected");
	AST_ASYNC_START: assert property (@(posedge CLK) disable iff (SRST)
		((state_ff == ST_INIT || state_ff == ST_RUN) && !RESET_INPUT_PIN_I && !rpd_ff)
		|=> state_ff == ST_ASYNC)
		else $error("low input with low cap did not go async");
	AST_PD_FOLLOWS: assert property (@(posedge CLK) disable iff (SRST)
		!RESET_INPUT_PIN_I |=> RPD_PD)
		else $error("cap pull-down off while input low");
	AST_SHORT_START: assert property (@(posedge CLK) disable iff (SRST)
		(state_ff == ST_RUN && rpd_ff && low_ff == 3'(FILTER_TCL))
		|=> state_ff == ST_SEQ && kind_ff[FLG_SHORT])
		else $error("filtered low pulse did not start short reset");
	AST_SWWD_P0: assert property (@(posedge CLK) disable iff (SRST)
		(seq_end && (kind_ff[FLG_SW] || kind_ff[FLG_WDT]))
		|=> (P0_CFG & 16'hE0FF) == (($past(P0_CFG) & 16'hE003)
		| P0_SET_SWWD))
		else $error("software or watchdog reset latched wrong bits");
	AST_LONG_FLAG: assert property (@(posedge CLK) disable iff (SRST)
		(post_end && !RESET_INPUT_PIN_I && kind_ff[FLG_SHORT])
		|=> flg_ff[FLG_LONG] && P0_CFG == $past(P0_I))
		else $error("stretched short reset not handled as long");
	AST_BIDIR_HW: assert property (@(posedge CLK) disable iff (SRST)
		(post_end && !RESET_INPUT_PIN_I && bidir_ff && !kind_ff[FLG_SHORT])
		|=> state_ff == ST_SEQ && kind_ff[FLG_SHORT]
		&& $stable(flg_ff[FLG_SW]))
		else $error("bidir reset with low input not turned to hw");
	AST_BIDIR_CLR: assert property (@(posedge CLK) disable iff (SRST)
		state_ff == ST_SEQ |=> !ctrl_ff[CTRL_BIDIR_BIT])
		else $error("bidir enable survived a reset sequence");
endmodule : rps_seq
`default_nettype wire

// ### tb/rps_ext.sv
// model of the board side: wired reset line and power-down capacitor
`timescale 1ns/1ps
`default_nettype none
module rps_ext #(
	parameter int CAP_MAX = 200, // full charge, in clock steps
	parameter int CAP_THR = 100  // input threshold of the cap pin
) (
	input  wire logic clk,       // system clock
	input  wire logic hold_low,  // external device pulls reset line low
	input  wire logic reset_input_pin_o,   // block drive value
	input  wire logic reset_input_pin_oe,  // block pull-down on
	input  wire logic rpd_pd,    // block cap pull-down on
	input  wire logic rpd_pu,    // block cap pull-up on
	output logic      reset_input_pin_lvl, // level seen on the reset line
	output logic      rpd_lvl    // cap pin above threshold
);
	// ---------------------------------------------------------------
	// reset line: pull-up, any low driver wins
	// ---------------------------------------------------------------
	assign reset_input_pin_lvl = ((reset_input_pin_oe && !reset_input_pin_o) || hold_low) ? 1'b0 : 1'b1;
	// ---------------------------------------------------------------
	// capacitor: slow charge through the board resistor, so a long
	// pull-down is needed before the pin reads low
	// ---------------------------------------------------------------
	int cap_ff = CAP_MAX; // charge level
	always_ff @(posedge clk) begin
		if (rpd_pd && cap_ff > 0) begin // discharge
			cap_ff <= cap_ff - 1;
		end else if (!rpd_pd && cap_ff < CAP_MAX) begin // recharge
			cap_ff <= cap_ff + (rpd_pu ? 2 : 1);
		end
	end
	assign rpd_lvl = (cap_ff >= CAP_THR);
endmodule : rps_ext
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the reset pin sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import rps_pkg::*;
;
	localparam int SL = 16; // shortened sequence length
	logic        CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, perr;
	logic [7:0]  PADDR;
	logic [31:0] PWDATA, PRDATA, rdat;
	logic        RESET_INPUT_PIN_I, RESET_INPUT_PIN_O, RESET_INPUT_PIN_OE, RESET_OUTPUT_PIN_N, RPD_I, RPD_PD;
	logic        RPD_PU, SW_RST, WDT_RST, END_OF_INITIALIZATION_INSTRUCTION, CORE_RST, IRQ, hold;
	logic [15:0] P0_I, P0_CFG, cfg_x;
	int          err_total, cmp_count;

	rps_seq #(.SEQ_LEN(SL)) rps_seq_i (.CLK(CLK), .SRST(SRST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
		.RESET_INPUT_PIN_I(RESET_INPUT_PIN_I), .RESET_INPUT_PIN_O(RESET_INPUT_PIN_O), .RESET_INPUT_PIN_OE(RESET_INPUT_PIN_OE),
		.RESET_OUTPUT_PIN_N(RESET_OUTPUT_PIN_N), .RPD_I(RPD_I), .RPD_PD(RPD_PD), .RPD_PU(RPD_PU),
		.P0_I(P0_I), .P0_CFG(P0_CFG), .SW_RST(SW_RST), .WDT_RST(WDT_RST),
		.END_OF_INITIALIZATION_INSTRUCTION(END_OF_INITIALIZATION_INSTRUCTION), .CORE_RST(CORE_RST), .IRQ(IRQ));
	rps_ext rps_ext_i (.clk(CLK), .hold_low(hold), .reset_input_pin_o(RESET_INPUT_PIN_O),
		.reset_input_pin_oe(RESET_INPUT_PIN_OE), .rpd_pd(RPD_PD), .rpd_pu(RPD_PU),
		.reset_input_pin_lvl(RESET_INPUT_PIN_I), .rpd_lvl(RPD_I));

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin // report at once
			err_total++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 16);
		r = PRDATA;
		perr = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
		chk(n < 16, "apb hang");
	endtask : apb
	// one-cycle request pulse: 0 software, 1 watchdog, 2 end of init
	task automatic pulse(input int k);
		SW_RST <= (k == 0);
		WDT_RST <= (k == 1);
		END_OF_INITIALIZATION_INSTRUCTION <= (k == 2);
		@(posedge CLK);
		SW_RST <= 1'b0;
		WDT_RST <= 1'b0;
		END_OF_INITIALIZATION_INSTRUCTION <= 1'b0;
		@(posedge CLK);
	endtask : pulse
	// poll the state register until initialization is reached
	task automatic wait_init();
		int n;
		n = 0;
		do begin
			apb(1'b0, OFF_STATE, 32'h0, rdat);
			n++;
		end while (rdat[4:0] !== 5'h08 && n < 200);
		chk(n < 200, "init never reached");
	endtask : wait_init
	task automatic flags_is(input logic [5:0] f);
		apb(1'b0, OFF_STATUS, 32'h0, rdat);
		chk(rdat[5:0] === f, "source flags");
		chk(P0_CFG === cfg_x, "latched configuration");
		apb(1'b1, OFF_STATUS, 32'h3F, rdat); // clear all flags
	endtask : flags_is

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic s_por();
		chk(RESET_OUTPUT_PIN_N === 1'b0 && CORE_RST === 1'b1, "reset state");
		wait_init();
		cfg_x = P0_I;
		apb(1'b1, OFF_MASK, 32'h20, rdat);
		repeat (2) @(posedge CLK);
		chk(IRQ === 1'b1, "irq not raised");
		flags_is(6'h20);
		repeat (2) @(posedge CLK);
		chk(IRQ === 1'b0, "irq not cleared");
		apb(1'b0, 8'h14, 32'h0, rdat);
		chk(perr === 1'b1 && rdat === 32'h0, "unmapped read");
	endtask : s_por
	// software or watchdog reset with bidir armed, optionally stretched
	task automatic s_swwd(input int k, input logic hl, input logic [15:0] p);
		P0_I <= p;
		apb(1'b1, OFF_CTRL, 32'h1, rdat);
		pulse(2);
		pulse(k);
		repeat (2) @(posedge CLK);
		chk(RESET_INPUT_PIN_OE === 1'b1 && CORE_RST === 1'b1, "bidir pull");
		chk(RESET_INPUT_PIN_O === 1'b0, "reset pin drive value");
		chk(RESET_OUTPUT_PIN_N === 1'b0, "reset output");
		hold <= hl;
		repeat (SL + 10) @(posedge CLK);
		hold <= 1'b0;
		wait_init();
		cfg_x = (cfg_x & ~(P0_MSK_SWWD | P0_SET_SWWD)) | (p & P0_MSK_SWWD)
			| P0_SET_SWWD;
		if (hl) begin // stretched into a short hardware reset
			cfg_x = (cfg_x & ~P0_MSK_SHORT) | (p & P0_MSK_SHORT);
			flags_is(6'h04);
		end else begin
			flags_is(k == 0 ? 6'h01 : 6'h02);
		end
		apb(1'b0, OFF_CTRL, 32'h0, rdat);
		chk(rdat[0] === 1'b0, "bidir enable survived reset");
	endtask : s_swwd
	task automatic s_ctrl();
		apb(1'b1, OFF_CTRL, 32'h2, rdat);
		pulse(2);
		chk(RESET_OUTPUT_PIN_N === 1'b1, "reset output not released");
		chk(RPD_PU === 1'b1, "cap pull-up off");
		apb(1'b1, OFF_CTRL, 32'h3, rdat);
		apb(1'b0, OFF_CTRL, 32'h0, rdat);
		chk(rdat[1:0] === 2'h2, "bidir set after init");
	endtask : s_ctrl
	// external low pulse of len cycles with the cap pin charged
	task automatic s_hw(input int len, input logic [15:0] p);
		P0_I <= p;
		hold <= 1'b1;
		repeat (3) @(posedge CLK);
		chk(RPD_PD === 1'b1, "cap pull-down off");
		repeat (len - 3) @(posedge CLK);
		hold <= 1'b0;
		wait_init();
		cfg_x = (len > 20) ? p : ((cfg_x & ~P0_MSK_SHORT) | (p & P0_MSK_SHORT));
		flags_is(len > 20 ? 6'h08 : 6'h04);
	endtask : s_hw
	task automatic s_async();
		P0_I <= 16'h6E91;
		hold <= 1'b1;
		repeat (250) @(posedge CLK);
		apb(1'b0, OFF_STATE, 32'h0, rdat);
		chk(rdat[4:0] === 5'h01, "not in async reset");
		hold <= 1'b0;
		wait_init();
		cfg_x = 16'h6E91;
		apb(1'b0, OFF_STATUS, 32'h0, rdat);
		chk(rdat[FLG_ASYNC] === 1'b1, "async flag");
		apb(1'b1, OFF_STATUS, 32'h3F, rdat);
		hold <= 1'b1; // cap still low: straight to async
		repeat (4) @(posedge CLK);
		apb(1'b0, OFF_STATE, 32'h0, rdat);
		chk(rdat[4:0] === 5'h01, "low cap not async");
		hold <= 1'b0;
		wait_init();
		flags_is(6'h10);
	endtask : s_async

	// ---------------------------------------------------------------
	// verdict, clock, watchdog and main sequence
	// ---------------------------------------------------------------
	task automatic stop_test();
		$display("errors %0d, comparisons %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	initial begin
		#100000;
		err_total++;
		stop_test();
	end
	initial begin
		{SRST, PSEL, PENABLE, PWRITE, SW_RST, WDT_RST, END_OF_INITIALIZATION_INSTRUCTION} <= 7'h40;
		{PADDR, PWDATA, hold, P0_I} <= {8'h00, 32'h0, 1'b0, 16'h3C5A};
		err_total = 0;
		cmp_count = 0;
		repeat (3) @(posedge CLK);
		SRST <= 1'b0;
		@(posedge CLK);
		s_por();
		s_swwd(0, 1'b0, 16'hA5C3);
		s_swwd(1, 1'b0, 16'h5A3C);
		s_swwd(0, 1'b1, 16'hC3A5);
		s_ctrl();
		s_hw(6, 16'h9696);
		s_hw(40, 16'h7E81);
		s_async();
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
